// >>> rtl/baro_pkg.sv
package baro_pkg;

   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_INT_CFG   = 7'h0B;
   localparam logic [ADDR_W-1:0] ADDR_THS_LOW   = 7'h0C;
   localparam logic [ADDR_W-1:0] ADDR_THS_HIGH  = 7'h0D;
   localparam logic [ADDR_W-1:0] ADDR_IDENT     = 7'h0F;
   localparam logic [ADDR_W-1:0] ADDR_CTRL1     = 7'h10;
   localparam logic [ADDR_W-1:0] ADDR_CTRL2     = 7'h11;
   localparam logic [ADDR_W-1:0] ADDR_CTRL3     = 7'h12;
   localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL = 7'h14;
   localparam logic [ADDR_W-1:0] ADDR_REF_XL    = 7'h15;
   localparam logic [ADDR_W-1:0] ADDR_REF_L     = 7'h16;
   localparam logic [ADDR_W-1:0] ADDR_REF_H     = 7'h17;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 7'h27;
   localparam logic [ADDR_W-1:0] ADDR_PRESS_XL  = 7'h28;
   localparam logic [ADDR_W-1:0] ADDR_PRESS_L   = 7'h29;
   localparam logic [ADDR_W-1:0] ADDR_PRESS_H   = 7'h2A;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_L    = 7'h2B;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_H    = 7'h2C;
   localparam logic [ADDR_W-1:0] ADDR_STEP      = 7'h01;

   // rate_filter_control fields
   localparam int RATE_MSB       = 6;
   localparam int RATE_LSB       = 4;
   localparam int LPF_EN_BIT     = 3;
   localparam int LPF_CFG_BIT    = 2;
   localparam int BDU_BIT        = 1;
   localparam int SPI_WIRE_BIT   = 0;
   localparam int CTRL1_RSVD_BIT = 7;

   // boot_reset_iface_control fields
   localparam int BOOT_BIT       = 7;
   localparam int FIFO_EN_BIT    = 6;
   localparam int WTM_STOP_BIT   = 5;
   localparam int AUTO_INC_BIT   = 4;
   localparam int TWOWIRE_BIT    = 3;
   localparam int SOFT_RST_BIT   = 2;
   localparam int CTRL2_RSVD_BIT = 1;
   localparam int ONE_SHOT_BIT   = 0;

   // Status fields
   localparam int STAT_T_DA_BIT = 0;
   localparam int STAT_P_DA_BIT = 1;
   localparam int STAT_T_OR_BIT = 4;
   localparam int STAT_P_OR_BIT = 5;

   // Reset values
   localparam logic [DATA_W-1:0] BYTE_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] CTRL2_RESET = 8'h10;
   // Identity value is arbitrary
   localparam logic [DATA_W-1:0] IDENT_CODE  = 8'h5A;

   // Rate codes
   localparam logic [2:0] RATE_OFF  = 3'h0;
   localparam logic [2:0] RATE_1HZ  = 3'h1;
   localparam logic [2:0] RATE_10HZ = 3'h2;
   localparam logic [2:0] RATE_25HZ = 3'h3;
   localparam logic [2:0] RATE_50HZ = 3'h4;
   localparam logic [2:0] RATE_75HZ = 3'h5;

   // Timing
   localparam int CLK_HZ     = 25_000_000;
   localparam int FREQ_1_HZ  = 1;
   localparam int FREQ_10_HZ = 10;
   localparam int FREQ_25_HZ = 25;
   localparam int FREQ_50_HZ = 50;
   localparam int FREQ_75_HZ = 75;

   // Bandwidth divisors of the rate
   localparam logic [4:0] BW_DIV_OPEN   = 5'h02;
   localparam logic [4:0] BW_DIV_MEDIUM = 5'h09;
   localparam logic [4:0] BW_DIV_NARROW = 5'h14;

   localparam int THS_W         = 16;
   localparam int THS_FRAC_BITS = 4;
   localparam int PRESS_W       = 24;
   localparam int TEMP_W        = 16;
   localparam int TRIM_W        = 8;
   localparam int TRIM_DEPTH    = 8;

   typedef enum logic [1:0] {BOOT_IDLE, BOOT_WAIT_TICK, BOOT_READ, BOOT_STORE} boot_state_t;

endpackage

// >>> rtl/trim_store.sv
`timescale 1ns/1ps
`default_nettype none
module trim_store #(
   parameter int                    WIDTH = 8,
   parameter int                    DEPTH = 8,
   parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rd_en,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);

   logic [WIDTH-1:0] next_rd_data;

   // Factory content is fixed; read data is registered
   always_comb begin
      next_rd_data = rd_data;
      if (rd_en) begin
         next_rd_data = INIT[rd_addr*WIDTH +: WIDTH];
      end
   end

   always_ff @(posedge clk_sys) begin
      rd_data <= next_rd_data;
   end

endmodule
`default_nettype wire

// >>> rtl/baro_sensor_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module baro_sensor_ctrl_regs
   import baro_pkg::*;
#(
   parameter int                                  PERIOD_1HZ  = CLK_HZ / FREQ_1_HZ,
   parameter int                                  PERIOD_10HZ = CLK_HZ / FREQ_10_HZ,
   parameter int                                  PERIOD_25HZ = CLK_HZ / FREQ_25_HZ,
   parameter int                                  PERIOD_50HZ = CLK_HZ / FREQ_50_HZ,
   parameter int                                  PERIOD_75HZ = CLK_HZ / FREQ_75_HZ,
   parameter logic [baro_pkg::TRIM_W*baro_pkg::TRIM_DEPTH-1:0] TRIM_INIT = 64'h8877665544332211
) (
   input  wire logic                          clk_sys,
   input  wire logic                          srst,
   input  wire logic                          reg_addr_load,
   input  wire logic [baro_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic [baro_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_rd,
   output logic      [baro_pkg::DATA_W-1:0]   reg_rdata,
   output logic                               reg_rvalid,
   output logic                               conv_start,
   input  wire logic                          conv_done,
   input  wire logic [baro_pkg::PRESS_W-1:0]  conv_pressure,
   input  wire logic [baro_pkg::TEMP_W-1:0]   conv_temp,
   output logic      [baro_pkg::THS_W-1:0]    threshold_value,
   output logic      [baro_pkg::THS_W-baro_pkg::THS_FRAC_BITS-1:0] threshold_hpa,
   output logic      [2:0]                    rate_select,
   output logic                               powered_down,
   output logic                               lowpass_enable,
   output logic                               lowpass_bandwidth_sel,
   output logic      [4:0]                    bandwidth_div,
   output logic                               spi_wire_select,
   output logic                               twowire_disable,
   output logic                               fifo_enable,
   output logic                               watermark_stop_enable,
   output logic      [baro_pkg::DATA_W-1:0]   interrupt_config,
   output logic      [baro_pkg::DATA_W-1:0]   pin_config,
   output logic      [baro_pkg::DATA_W-1:0]   fifo_config,
   output logic      [baro_pkg::PRESS_W-1:0]  reference_value,
   output logic                               boot_active,
   output logic      [baro_pkg::TRIM_DEPTH-1:0][baro_pkg::TRIM_W-1:0] calib_data
);
   import baro_pkg::*;

   localparam int CNT_W = $clog2(PERIOD_1HZ + 1);
   localparam int IDX_W = $clog2(TRIM_DEPTH);

   function automatic logic [2:0] legal_rate(input logic [2:0] code);
      legal_rate = (code > RATE_75HZ) ? RATE_OFF : code;
   endfunction

   function automatic logic [CNT_W-1:0] last_count(input logic [2:0] code);
      unique case (code)
         RATE_10HZ: last_count = CNT_W'(PERIOD_10HZ - 1);
         RATE_25HZ: last_count = CNT_W'(PERIOD_25HZ - 1);
         RATE_50HZ: last_count = CNT_W'(PERIOD_50HZ - 1);
         RATE_75HZ: last_count = CNT_W'(PERIOD_75HZ - 1);
         default:   last_count = CNT_W'(PERIOD_1HZ - 1);
      endcase
   endfunction

   // Register file state
   logic [DATA_W-1:0]  int_cfg, ths_low, ths_high, ctrl1, ctrl2, ctrl3, fifo_ctrl;
   logic [DATA_W-1:0]  ref_xl, ref_l, ref_h, status;
   logic [ADDR_W-1:0]  pointer;
   logic [PRESS_W-1:0] press_out, press_shadow;
   logic [TEMP_W-1:0]  temp_out, temp_shadow;
   logic               pending, bdu_locked;
   logic [DATA_W-1:0]  next_int_cfg, next_ths_low, next_ths_high, next_ctrl1, next_ctrl2;
   logic [DATA_W-1:0]  next_ctrl3, next_fifo_ctrl, next_ref_xl, next_ref_l, next_ref_h, next_status;
   logic [ADDR_W-1:0]  next_pointer;
   logic [PRESS_W-1:0] next_press_out, next_press_shadow;
   logic [TEMP_W-1:0]  next_temp_out, next_temp_shadow;
   logic               next_pending, next_bdu_locked;
   logic [DATA_W-1:0]  next_reg_rdata;
   logic               next_reg_rvalid;

   // Rate timer, acquisition and boot state
   logic [CNT_W-1:0]   rate_count, next_rate_count;
   logic [2:0]         rate_prev, next_rate_prev;
   logic               rate_tick;
   logic               acq_busy, acq_oneshot, next_acq_busy, next_acq_oneshot, next_conv_start;
   logic               sample_valid, oneshot_done;
   boot_state_t        boot_state, next_boot_state;
   logic [IDX_W-1:0]   boot_idx, next_boot_idx;
   logic               boot_reload, next_boot_reload, boot_done;
   logic [TRIM_DEPTH-1:0][TRIM_W-1:0] next_calib_data;
   logic [TRIM_W-1:0]  trim_rd_data;
   logic               trim_rd_en;

   logic [ADDR_W-1:0]  acc_addr;
   logic               rd_msb, lock_eff, load_out;
   logic [2:0]         eff_rate;

   assign acc_addr     = reg_addr_load ? reg_addr : pointer;
   assign eff_rate     = legal_rate(ctrl1[RATE_MSB:RATE_LSB]);
   assign sample_valid = acq_busy && conv_done;
   assign oneshot_done = sample_valid && acq_oneshot;

   // Outputs decoded combinationally from registers
   assign threshold_value       = {ths_high, ths_low};
   assign threshold_hpa         = threshold_value[THS_W-1:THS_FRAC_BITS];
   assign rate_select           = eff_rate;
   assign powered_down          = (eff_rate == RATE_OFF) && !acq_busy;
   assign lowpass_enable        = ctrl1[LPF_EN_BIT];
   assign lowpass_bandwidth_sel = ctrl1[LPF_CFG_BIT];
   assign spi_wire_select       = ctrl1[SPI_WIRE_BIT];
   assign twowire_disable       = ctrl2[TWOWIRE_BIT];
   assign fifo_enable           = ctrl2[FIFO_EN_BIT];
   assign watermark_stop_enable = ctrl2[WTM_STOP_BIT];
   assign interrupt_config      = int_cfg;
   assign pin_config            = ctrl3;
   assign fifo_config           = fifo_ctrl;
   assign reference_value       = {ref_h, ref_l, ref_xl};
   assign boot_active           = (boot_state == BOOT_READ) || (boot_state == BOOT_STORE);

   always_comb begin
      bandwidth_div = BW_DIV_OPEN;
      if (ctrl1[LPF_EN_BIT]) begin
         bandwidth_div = ctrl1[LPF_CFG_BIT] ? BW_DIV_NARROW : BW_DIV_MEDIUM;
      end
   end

   // Register file
   always_comb begin
      next_int_cfg      = int_cfg;
      next_ths_low      = ths_low;
      next_ths_high     = ths_high;
      next_ctrl1        = ctrl1;
      next_ctrl2        = ctrl2;
      next_ctrl3        = ctrl3;
      next_fifo_ctrl    = fifo_ctrl;
      next_ref_xl       = ref_xl;
      next_ref_l        = ref_l;
      next_ref_h        = ref_h;
      next_status       = status;
      next_pointer      = reg_addr_load ? reg_addr : pointer;
      next_press_out    = press_out;
      next_temp_out     = temp_out;
      next_press_shadow = press_shadow;
      next_temp_shadow  = temp_shadow;
      next_pending      = pending;
      next_bdu_locked   = bdu_locked && ctrl1[BDU_BIT];
      next_reg_rdata    = reg_rdata;
      next_reg_rvalid   = reg_rd;

      // Hardware clears come first so a same-cycle host write wins
      if (boot_done) begin
         next_ctrl2[BOOT_BIT] = 1'b0;
      end
      if (oneshot_done || (eff_rate != RATE_OFF)) begin
         next_ctrl2[ONE_SHOT_BIT] = 1'b0;
      end

      if (reg_rd) begin
         unique case (acc_addr)
            ADDR_INT_CFG:   next_reg_rdata = int_cfg;
            ADDR_THS_LOW:   next_reg_rdata = ths_low;
            ADDR_THS_HIGH:  next_reg_rdata = ths_high;
            ADDR_IDENT:     next_reg_rdata = IDENT_CODE;
            ADDR_CTRL1:     next_reg_rdata = ctrl1;
            ADDR_CTRL2:     next_reg_rdata = ctrl2;
            ADDR_CTRL3:     next_reg_rdata = ctrl3;
            ADDR_FIFO_CTRL: next_reg_rdata = fifo_ctrl;
            ADDR_REF_XL:    next_reg_rdata = ref_xl;
            ADDR_REF_L:     next_reg_rdata = ref_l;
            ADDR_REF_H:     next_reg_rdata = ref_h;
            ADDR_STATUS:    next_reg_rdata = status;
            ADDR_PRESS_XL:  next_reg_rdata = press_out[7:0];
            ADDR_PRESS_L:   next_reg_rdata = press_out[15:8];
            ADDR_PRESS_H:   next_reg_rdata = press_out[23:16];
            ADDR_TEMP_L:    next_reg_rdata = temp_out[7:0];
            ADDR_TEMP_H:    next_reg_rdata = temp_out[15:8];
            default:        next_reg_rdata = BYTE_RESET;
         endcase
         if (acc_addr == ADDR_PRESS_H) begin
            next_status[STAT_P_DA_BIT] = 1'b0;
            next_status[STAT_P_OR_BIT] = 1'b0;
         end
         if (acc_addr == ADDR_TEMP_H) begin
            next_status[STAT_T_DA_BIT] = 1'b0;
            next_status[STAT_T_OR_BIT] = 1'b0;
         end
      end

      if (reg_wr) begin
         unique case (acc_addr)
            ADDR_INT_CFG:   next_int_cfg   = reg_wdata;
            ADDR_THS_LOW:   next_ths_low   = reg_wdata;
            ADDR_THS_HIGH:  next_ths_high  = reg_wdata;
            ADDR_CTRL1: begin
               next_ctrl1 = reg_wdata;
               next_ctrl1[CTRL1_RSVD_BIT] = 1'b0;
            end
            ADDR_CTRL2: begin
               next_ctrl2 = reg_wdata;
               next_ctrl2[CTRL2_RSVD_BIT] = 1'b0;
            end
            ADDR_CTRL3:     next_ctrl3     = reg_wdata;
            ADDR_FIFO_CTRL: next_fifo_ctrl = reg_wdata;
            ADDR_REF_XL:    next_ref_xl    = reg_wdata;
            ADDR_REF_L:     next_ref_l     = reg_wdata;
            ADDR_REF_H:     next_ref_h     = reg_wdata;
            default: begin
            end
         endcase
      end

      if ((reg_rd || reg_wr) && ctrl2[AUTO_INC_BIT]) begin
         next_pointer = acc_addr + ADDR_STEP;
      end

      // Sample capture, held back while block update is locked
      rd_msb   = reg_rd && (acc_addr == ADDR_PRESS_H);
      lock_eff = bdu_locked && ctrl1[BDU_BIT] && !rd_msb;
      if (rd_msb) begin
         next_bdu_locked = 1'b0;
      end
      if (sample_valid) begin
         next_press_shadow = conv_pressure;
         next_temp_shadow  = conv_temp;
         next_pending      = 1'b1;
         next_status[STAT_P_OR_BIT] = status[STAT_P_DA_BIT] || next_status[STAT_P_OR_BIT];
         next_status[STAT_T_OR_BIT] = status[STAT_T_DA_BIT] || next_status[STAT_T_OR_BIT];
         next_status[STAT_P_DA_BIT] = 1'b1;
         next_status[STAT_T_DA_BIT] = 1'b1;
      end
      load_out = (sample_valid || pending) && !lock_eff;
      if (load_out) begin
         next_press_out  = sample_valid ? conv_pressure : press_shadow;
         next_temp_out   = sample_valid ? conv_temp : temp_shadow;
         next_pending    = 1'b0;
         next_bdu_locked = ctrl1[BDU_BIT];
      end

      // Soft reset takes the cycle after the bit is stored
      if (ctrl2[SOFT_RST_BIT]) begin
         next_int_cfg   = BYTE_RESET;
         next_ths_low   = BYTE_RESET;
         next_ths_high  = BYTE_RESET;
         next_ctrl1     = BYTE_RESET;
         next_ctrl2     = CTRL2_RESET;
         next_ctrl3     = BYTE_RESET;
         next_fifo_ctrl = BYTE_RESET;
         next_ref_xl    = BYTE_RESET;
         next_ref_l     = BYTE_RESET;
         next_ref_h     = BYTE_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         int_cfg      <= BYTE_RESET;
         ths_low      <= BYTE_RESET;
         ths_high     <= BYTE_RESET;
         ctrl1        <= BYTE_RESET;
         ctrl2        <= CTRL2_RESET;
         ctrl3        <= BYTE_RESET;
         fifo_ctrl    <= BYTE_RESET;
         ref_xl       <= BYTE_RESET;
         ref_l        <= BYTE_RESET;
         ref_h        <= BYTE_RESET;
         status       <= BYTE_RESET;
         pointer      <= '0;
         press_out    <= '0;
         temp_out     <= '0;
         press_shadow <= '0;
         temp_shadow  <= '0;
         pending      <= 1'b0;
         bdu_locked   <= 1'b0;
         reg_rdata    <= BYTE_RESET;
         reg_rvalid   <= 1'b0;
      end else begin
         int_cfg      <= next_int_cfg;
         ths_low      <= next_ths_low;
         ths_high     <= next_ths_high;
         ctrl1        <= next_ctrl1;
         ctrl2        <= next_ctrl2;
         ctrl3        <= next_ctrl3;
         fifo_ctrl    <= next_fifo_ctrl;
         ref_xl       <= next_ref_xl;
         ref_l        <= next_ref_l;
         ref_h        <= next_ref_h;
         status       <= next_status;
         pointer      <= next_pointer;
         press_out    <= next_press_out;
         temp_out     <= next_temp_out;
         press_shadow <= next_press_shadow;
         temp_shadow  <= next_temp_shadow;
         pending      <= next_pending;
         bdu_locked   <= next_bdu_locked;
         reg_rdata    <= next_reg_rdata;
         reg_rvalid   <= next_reg_rvalid;
      end
   end

   // Rate clock; runs at the slowest rate in power-down for reboot timing
   assign rate_tick = (rate_count == last_count(eff_rate)) && (eff_rate == rate_prev);

   always_comb begin
      next_rate_prev  = eff_rate;
      next_rate_count = rate_count + CNT_W'(1);
      if (rate_tick || (eff_rate != rate_prev)) begin
         next_rate_count = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rate_count <= '0;
         rate_prev  <= RATE_OFF;
      end else begin
         rate_count <= next_rate_count;
         rate_prev  <= next_rate_prev;
      end
   end

   // Acquisition sequencing
   always_comb begin
      next_acq_busy    = acq_busy;
      next_acq_oneshot = acq_oneshot;
      next_conv_start  = 1'b0;
      if (sample_valid) begin
         next_acq_busy    = 1'b0;
         next_acq_oneshot = 1'b0;
      end else if (!acq_busy && !boot_active) begin
         if (eff_rate != RATE_OFF && rate_tick) begin
            next_conv_start = 1'b1;
            next_acq_busy   = 1'b1;
         end else if (eff_rate == RATE_OFF && ctrl2[ONE_SHOT_BIT]) begin
            next_conv_start  = 1'b1;
            next_acq_busy    = 1'b1;
            next_acq_oneshot = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acq_busy    <= 1'b0;
         acq_oneshot <= 1'b0;
         conv_start  <= 1'b0;
      end else begin
         acq_busy    <= next_acq_busy;
         acq_oneshot <= next_acq_oneshot;
         conv_start  <= next_conv_start;
      end
   end

   // Trim load at reset and on reboot
   assign trim_rd_en = (boot_state == BOOT_READ);
   assign boot_done  = (boot_state == BOOT_STORE) && (boot_idx == IDX_W'(TRIM_DEPTH - 1)) && boot_reload;

   always_comb begin
      next_boot_state  = boot_state;
      next_boot_idx    = boot_idx;
      next_boot_reload = boot_reload;
      next_calib_data  = calib_data;
      unique case (boot_state)
         BOOT_IDLE: begin
            if (ctrl2[BOOT_BIT]) begin
               next_boot_state  = BOOT_WAIT_TICK;
               next_boot_reload = 1'b1;
            end
         end
         BOOT_WAIT_TICK: begin
            if (rate_tick) begin
               next_boot_state = BOOT_READ;
               next_boot_idx   = '0;
            end
         end
         BOOT_READ: next_boot_state = BOOT_STORE;
         BOOT_STORE: begin
            next_calib_data[boot_idx] = trim_rd_data;
            if (boot_idx == IDX_W'(TRIM_DEPTH - 1)) begin
               next_boot_state  = BOOT_IDLE;
               next_boot_reload = 1'b0;
            end else begin
               next_boot_state = BOOT_READ;
               next_boot_idx   = boot_idx + IDX_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         boot_state  <= BOOT_READ;
         boot_idx    <= '0;
         boot_reload <= 1'b0;
         calib_data  <= '0;
      end else begin
         boot_state  <= next_boot_state;
         boot_idx    <= next_boot_idx;
         boot_reload <= next_boot_reload;
         calib_data  <= next_calib_data;
      end
   end

   trim_store #(
      .WIDTH (TRIM_W),
      .DEPTH (TRIM_DEPTH),
      .INIT  (TRIM_INIT)
   ) u_trim_store (
      .clk_sys (clk_sys),
      .rd_en   (trim_rd_en),
      .rd_addr (boot_idx),
      .rd_data (trim_rd_data)
   );

endmodule
`default_nettype wire

// >>> tb/baro_checker.sv
`timescale 1ns/1ps
`default_nettype none
module baro_checker (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic       reg_rd,
   input wire logic       reg_rvalid,
   input wire logic       conv_start,
   input wire logic [2:0] rate_select,
   input wire logic       powered_down,
   input wire logic       lowpass_enable,
   input wire logic       lowpass_bandwidth_sel,
   input wire logic [4:0] bandwidth_div,
   input wire logic       boot_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   bw_open_a: assert property (!lowpass_enable |-> bandwidth_div == 5'h02) else $error("bw open");
   bw_medium_a: assert property (lowpass_enable && !lowpass_bandwidth_sel |-> bandwidth_div == 5'h09)
      else $error("bw medium");
   bw_narrow_a: assert property (lowpass_enable && lowpass_bandwidth_sel |-> bandwidth_div == 5'h14)
      else $error("bw narrow");
   rate_legal_a: assert property (rate_select <= 3'h5) else $error("undefined rate shown");
   start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start too long");
   down_rate_a: assert property (powered_down |-> rate_select == 3'h0) else $error("down at rate");
   boot_blocks_a: assert property (boot_active ##1 boot_active |-> !conv_start) else $error("start in boot");
   cover property (conv_start && rate_select == 3'h0);
   cover property (lowpass_enable && lowpass_bandwidth_sel);
   cover property (conv_start && rate_select == 3'h1);
endmodule
bind baro_sensor_ctrl_regs baro_checker i_baro_checker (.clk_sys, .srst, .reg_rd, .reg_rvalid, .conv_start,
   .rate_select, .powered_down, .lowpass_enable, .lowpass_bandwidth_sel, .bandwidth_div, .boot_active);
`default_nettype wire

// >>> tb/sensor_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_front_model (
   input  wire logic        clk_sys,
   input  wire logic        conv_start,
   input  wire logic        slow,
   output logic             conv_done,
   output logic      [23:0] conv_pressure,
   output logic      [15:0] conv_temp
);
   int          cnt = 0;
   logic [23:0] seq = 24'h13579B;
   // Data lines change every cycle, only the done cycle holds a sample
   always @(posedge clk_sys) begin
      seq <= seq + 24'h01F3A7;
      conv_done <= cnt == 1;
      cnt <= conv_start ? (slow ? 12 : 3) : (cnt > 0 ? cnt - 1 : 0);
   end
   assign conv_pressure = seq;
   assign conv_temp = ~seq[15:0];
endmodule
`default_nettype wire

// >>> tb/baro_sensor_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module baro_sensor_ctrl_regs_tb_top;
   import baro_pkg::*;
   logic        clk_sys = 0, srst = 1, reg_addr_load = 0, reg_wr = 0, reg_rd = 0, slow = 0;
   logic [6:0]  reg_addr = '0;
   logic [7:0]  reg_wdata = '0, rd, reg_rdata;
   logic [23:0] conv_pressure, smp[$];
   logic [15:0] conv_temp, threshold_value;
   logic [11:0] threshold_hpa;
   logic [2:0]  rate_select;
   logic        reg_rvalid, conv_start, conv_done, powered_down, spi_wire_select;
   logic        twowire_disable, fifo_enable, watermark_stop_enable, boot_active;
   logic [63:0] calib_data;
   logic [23:0] reference_value;
   localparam logic [63:0] TRIM = 64'h0F1E2D3C4B5A6978;
   logic [31:0] s = 52, v;
   int          miscompares = 0, checked = 0, n;
   baro_sensor_ctrl_regs #(.PERIOD_1HZ(100), .PERIOD_10HZ(50), .PERIOD_25HZ(40), .PERIOD_50HZ(30),
      .PERIOD_75HZ(20), .TRIM_INIT(TRIM)) i_baro_sensor_ctrl_regs (.clk_sys, .srst, .reg_addr_load, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .conv_start, .conv_done, .conv_pressure, .conv_temp,
      .threshold_value, .threshold_hpa, .rate_select, .powered_down, .lowpass_enable(),
      .lowpass_bandwidth_sel(), .bandwidth_div(), .spi_wire_select, .twowire_disable, .fifo_enable,
      .watermark_stop_enable, .interrupt_config(), .pin_config(), .fifo_config(), .reference_value,
      .boot_active, .calib_data);
   sensor_front_model i_sensor_front_model (.clk_sys, .conv_start, .slow, .conv_done, .conv_pressure,
      .conv_temp);
   initial forever #20 clk_sys = ~clk_sys;
   task conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [79:0] a, b);
      checked++;
      if (a !== b) begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, a, b);
      end
   endtask
   task acc(input logic [6:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      {reg_addr_load, reg_addr, reg_wr, reg_rd, reg_wdata} = {1'b1, a, w, !w, d};
      @(posedge clk_sys);
      #1;
      {reg_addr_load, reg_wr, reg_rd} = '0;
      rd = reg_rdata;
   endtask
   function void rnd;
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      v = s;
   endfunction
   // Wait for a finished conversion and keep its sample
   task wdone;
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end while (conv_done !== 1 && n < 300);
      chk(conv_done, 1'b1);
      smp.push_back(conv_pressure);
   endtask
   task wst;
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end while (conv_start !== 1 && n < 400);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 srst = 0;
      acc(ADDR_IDENT, 0, 0);
      chk({fifo_enable, watermark_stop_enable, twowire_disable, rd}, {3'h0, IDENT_CODE});
      acc(7'h13, 0, 0);
      chk(rd, 8'h00);
      rnd;
      acc(ADDR_THS_HIGH, 1, v[15:8]);
      acc(ADDR_THS_LOW, 1, v[7:0]);
      @(posedge clk_sys);
      #1;
      reg_rd = 1;
      @(posedge clk_sys);
      #1;
      reg_rd = 0;
      chk(reg_rdata, v[15:8]);
      acc(ADDR_THS_HIGH, 0, 0);
      chk({rd, threshold_value}, {v[15:8], v[15:0]});
      chk(threshold_hpa, v[15:4]);
      for (int c = 0; c < 8; c++) begin
         rnd;
         acc(ADDR_CTRL1, 1, {1'b0, c[2:0], v[3:0]});
         acc(ADDR_CTRL1, 0, 0);
         chk({rd, rate_select, spi_wire_select}, {1'b0, c[2:0], v[3:0], c > 5 ? 3'h0 : c[2:0], v[0]});
      end
      chk({boot_active, calib_data}, {1'b0, TRIM});
      acc(ADDR_CTRL2, 1, 8'h68);
      acc(ADDR_CTRL2, 0, 0);
      chk({fifo_enable, watermark_stop_enable, twowire_disable, rd}, {3'h7, 8'h68});
      acc(ADDR_REF_H, 1, 8'hA5);
      chk(reference_value, 24'hA50000);
      acc(ADDR_CTRL2, 1, 8'h04);
      repeat (2) @(posedge clk_sys);
      acc(ADDR_THS_HIGH, 0, 0);
      chk({rd, threshold_value, reference_value}, 48'h0);
      acc(ADDR_CTRL2, 0, 0);
      chk({twowire_disable, rd}, {1'b0, CTRL2_RESET});
      acc(ADDR_CTRL2, 1, 8'h90);
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end while (boot_active !== 1 && n < 300);
      chk(n < 104, 1'b1);
      repeat (16) @(posedge clk_sys);
      acc(ADDR_CTRL2, 0, 0);
      chk({boot_active, rd, calib_data}, {1'b0, CTRL2_RESET, TRIM});
      rnd;
      slow = v[0];
      acc(ADDR_CTRL2, 1, 8'h11);
      wdone;
      acc(ADDR_PRESS_H, 0, 0);
      chk(rd, smp[$][23:16]);
      acc(ADDR_CTRL2, 0, 0);
      chk({powered_down, rd}, {1'b1, CTRL2_RESET});
      acc(ADDR_CTRL1, 1, 8'h10);
      wst;
      wst;
      chk(n, 100);
      wdone;
      acc(ADDR_CTRL1, 1, 8'h12);
      wdone;
      wdone;
      acc(ADDR_PRESS_XL, 0, 0);
      chk(rd, smp[2][7:0]);
      acc(ADDR_PRESS_H, 0, 0);
      chk(rd, smp[2][23:16]);
      acc(ADDR_PRESS_XL, 0, 0);
      chk(rd, smp[3][7:0]);
      acc(ADDR_CTRL1, 1, 8'h00);
      wst;
      acc(ADDR_PRESS_XL, 0, 0);
      chk({n[15:0], rd}, {16'd400, smp[3][7:0]});
      conclude;
   end
   initial begin
      #800000;
      miscompares++;
      conclude;
   end
endmodule
`default_nettype wire
